// ### hdl/wdc_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH

`define WDC_OFF_CTRL 8'h00
`define WDC_OFF_MIN_DIAM 8'h04
`define WDC_OFF_MIN_SPEED 8'h08
`define WDC_OFF_PRESET 8'h0c
`define WDC_OFF_RAMP 8'h10
`define WDC_OFF_DIAM 8'h14
`define WDC_OFF_STATUS 8'h18

`define WDC_CTRL_ENABLE 0
`define WDC_CTRL_PRESET 1
`define WDC_STAT_CALC 0
`define WDC_STAT_PRESET 1
`define WDC_STAT_SETTLED 2

// Percent values are in hundredths of a percent
`define WDC_FULL_SCALE 16'h2710
`define WDC_IN_LIMIT 16'h2904
`define WDC_RST_MIN_DIAM 16'h03e8
`define WDC_RST_MIN_SPEED 16'h01f4
`define WDC_RST_PRESET 16'h03e8
// Ramp time is in tenths of a second: 5.0 s default, 0.1 s to 600.0 s
`define WDC_RST_RAMP 16'h0032
`define WDC_RAMP_MIN 16'h0001
`define WDC_RAMP_MAX 16'h1770

// One 0.01 % output step per 10 us for each 0.1 s of ramp time
`define WDC_CLK_PERIOD_NS 25
`define WDC_STEP_UNIT_NS 10000
`define WDC_STEP_CYC (`WDC_STEP_UNIT_NS / `WDC_CLK_PERIOD_NS)

`endif

// ### hdl/wdc_pkg.sv
// Types shared by the roll diameter calculator
package wdc_pkg;

    typedef enum logic [1:0] {
        WDC_IDLE = 2'b00,
        WDC_DIV = 2'b01,
        WDC_DONE = 2'b11
    } wdc_state_e;

    typedef struct packed {
        logic enable;
        logic sw_preset;
        logic [15:0] min_diam;
        logic [15:0] min_speed;
        logic [15:0] preset_val;
        logic [15:0] ramp_time;
    } wdc_cfg_s;

    typedef struct packed {
        logic calc_on;
        logic preset_on;
        logic settled;
    } wdc_stat_s;

endpackage

// ### hdl/wdc_diameter_calc.sv
// Winder roll diameter calculator with Wishbone register slave
//
// Function
// - Diameter is line rate over spindle rate, as percent of full roll.
// - Estimator stays inactive until its output destination is enabled.
// - Diameter updates only while line rate magnitude exceeds threshold.
// - Below threshold the output holds the last calculated diameter.
// - While preset is true the output takes the preset ratio.
// - Output slews so a full 100% change takes the ramp time, default 5 s.
// - Output never falls below core floor; floor also clamps calculation.
// - Ramp time 0.1 to 600 s; rate inputs limited to plus minus 105%.
`timescale 1ns/1ps
`include "wdc_defines.svh"

module wdc_diameter_calc #(
    parameter int STEP_CYC = `WDC_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Rate inputs and roll-change preset
    input wire logic signed [15:0] line_speed_i,
    input wire logic signed [15:0] reel_speed_i,
    input wire logic ext_preset_i,
    // Diameter result
    output logic [15:0] diameter_o,
    output logic calc_on_o
);

    wdc_pkg::wdc_cfg_s cfg_r;
    wdc_pkg::wdc_stat_s stat;
    wdc_pkg::wdc_state_e state_r;
    logic [26:0] num_r;
    logic [13:0] den_r;
    logic [14:0] rem_r;
    logic [26:0] quo_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] target_r;
    logic [15:0] diam_r;
    logic calc_on_r;
    logic [15:0] sub_cnt_r;
    logic [15:0] tenth_cnt_r;
    logic step_en;
    logic [13:0] line_mag;
    logic [13:0] reel_mag;
    logic [14:0] rem_sh;
    logic take;
    logic preset;
    logic [15:0] floor_val;
    logic [15:0] preset_eff;
    logic [26:0] quo_clamp;
    logic wr;
    logic [15:0] ramp_new;

    // Saturate a signed rate to the accepted span and return its magnitude
    function automatic logic [13:0] sat_mag(input logic signed [15:0] v);
        logic [15:0] m;
        m = v[15] ? 16'(-v) : 16'(v);
        if (m > `WDC_IN_LIMIT) begin
            m = `WDC_IN_LIMIT;
        end
        return m[13:0];
    endfunction

    // Byte-lane merge of a 16-bit field
    function automatic logic [15:0] lane16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
        logic [15:0] n;
        n = old;
        if (s[0]) begin
            n[7:0] = d[7:0];
        end
        if (s[1]) begin
            n[15:8] = d[15:8];
        end
        return n;
    endfunction

    function automatic logic [15:0] cap_full(input logic [15:0] v);
        return (v > `WDC_FULL_SCALE) ? `WDC_FULL_SCALE : v;
    endfunction

    assign line_mag = sat_mag(line_speed_i);
    assign reel_mag = sat_mag(reel_speed_i);
    assign floor_val = cfg_r.min_diam;
    assign preset = ext_preset_i | cfg_r.sw_preset;
    assign preset_eff = (cfg_r.preset_val < floor_val) ? floor_val
                                                        : cfg_r.preset_val;
    assign rem_sh = {rem_r[13:0], num_r[26]};
    assign wr = cyc_i & stb_i & we_i & ~ack_o;
    assign ramp_new = lane16(cfg_r.ramp_time, dat_i, sel_i);

    assign take = cfg_r.enable & ({2'b00, line_mag} > cfg_r.min_speed)
                  & (reel_mag != 14'h0000);

    always_comb begin
        quo_clamp = quo_r;
        if (quo_r > {11'h000, `WDC_FULL_SCALE}) begin
            quo_clamp = {11'h000, `WDC_FULL_SCALE};
        end
        if (quo_clamp < {11'h000, floor_val}) begin
            quo_clamp = {11'h000, floor_val};
        end
    end

    assign stat.calc_on = calc_on_r;
    assign stat.preset_on = preset;
    assign stat.settled = (diam_r == target_r);

    // Wishbone answer: one wait state, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (cyc_i & stb_i & ~we_i & ~ack_o) begin
            if (adr_i == `WDC_OFF_CTRL) begin
                dat_o <= {30'h0, cfg_r.sw_preset, cfg_r.enable};
            end else if (adr_i == `WDC_OFF_MIN_DIAM) begin
                dat_o <= {16'h0000, cfg_r.min_diam};
            end else if (adr_i == `WDC_OFF_MIN_SPEED) begin
                dat_o <= {16'h0000, cfg_r.min_speed};
            end else if (adr_i == `WDC_OFF_PRESET) begin
                dat_o <= {16'h0000, cfg_r.preset_val};
            end else if (adr_i == `WDC_OFF_RAMP) begin
                dat_o <= {16'h0000, cfg_r.ramp_time};
            end else if (adr_i == `WDC_OFF_DIAM) begin
                dat_o <= {16'h0000, diam_r};
            end else if (adr_i == `WDC_OFF_STATUS) begin
                dat_o <= {29'h0, stat.settled, stat.preset_on, stat.calc_on};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    // Configuration writes; percentages cap at full scale
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r.enable <= 1'b0;
            cfg_r.sw_preset <= 1'b0;
            cfg_r.min_diam <= `WDC_RST_MIN_DIAM;
            cfg_r.min_speed <= `WDC_RST_MIN_SPEED;
            cfg_r.preset_val <= `WDC_RST_PRESET;
            cfg_r.ramp_time <= `WDC_RST_RAMP;
        end else if (wr) begin
            if (adr_i == `WDC_OFF_CTRL) begin
                if (sel_i[0]) begin
                    cfg_r.enable <= dat_i[`WDC_CTRL_ENABLE];
                    cfg_r.sw_preset <= dat_i[`WDC_CTRL_PRESET];
                end
            end else if (adr_i == `WDC_OFF_MIN_DIAM) begin
                cfg_r.min_diam <= cap_full(lane16(cfg_r.min_diam, dat_i,
                                                  sel_i));
            end else if (adr_i == `WDC_OFF_MIN_SPEED) begin
                cfg_r.min_speed <= cap_full(lane16(cfg_r.min_speed, dat_i,
                                                   sel_i));
            end else if (adr_i == `WDC_OFF_PRESET) begin
                cfg_r.preset_val <= cap_full(lane16(cfg_r.preset_val, dat_i,
                                                    sel_i));
            end else if (adr_i == `WDC_OFF_RAMP) begin
                if (ramp_new < `WDC_RAMP_MIN) begin
                    cfg_r.ramp_time <= `WDC_RAMP_MIN;
                end else if (ramp_new > `WDC_RAMP_MAX) begin
                    cfg_r.ramp_time <= `WDC_RAMP_MAX;
                end else begin
                    cfg_r.ramp_time <= ramp_new;
                end
            end
        end
    end

    // Restoring divider: 27 quotient bits, one per cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= wdc_pkg::WDC_IDLE;
            num_r <= 27'h0;
            den_r <= 14'h0;
            rem_r <= 15'h0;
            quo_r <= 27'h0;
            bit_cnt_r <= 5'h0;
        end else begin
            case (state_r)
                wdc_pkg::WDC_IDLE: begin
                    if (take & ~preset) begin
                        num_r <= 27'({13'h0, line_mag} * 27'd10000);
                        den_r <= reel_mag;
                        rem_r <= 15'h0;
                        quo_r <= 27'h0;
                        bit_cnt_r <= 5'd26;
                        state_r <= wdc_pkg::WDC_DIV;
                    end
                end
                wdc_pkg::WDC_DIV: begin
                    num_r <= {num_r[25:0], 1'b0};
                    if (rem_sh >= {1'b0, den_r}) begin
                        rem_r <= rem_sh - {1'b0, den_r};
                        quo_r <= {quo_r[25:0], 1'b1};
                    end else begin
                        rem_r <= rem_sh;
                        quo_r <= {quo_r[25:0], 1'b0};
                    end
                    if (bit_cnt_r == 5'h0) begin
                        state_r <= wdc_pkg::WDC_DONE;
                    end else begin
                        bit_cnt_r <= bit_cnt_r - 5'h1;
                    end
                end
                wdc_pkg::WDC_DONE: begin
                    state_r <= wdc_pkg::WDC_IDLE;
                end
                default: begin
                    state_r <= wdc_pkg::WDC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            calc_on_r <= 1'b0;
        end else begin
            calc_on_r <= take & ~preset;
        end
    end

    // Target diameter: preset wins, otherwise a finished quotient
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            target_r <= `WDC_RST_MIN_DIAM;
        end else if (preset) begin
            target_r <= preset_eff;
        end else if (state_r == wdc_pkg::WDC_DONE && take) begin
            target_r <= quo_clamp[15:0];
        end else if (target_r < floor_val) begin
            target_r <= floor_val;
        end
    end

    // Step pacing: one 0.01 % step per ramp_time x STEP_CYC cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_cnt_r <= 16'h0;
            tenth_cnt_r <= 16'h0;
            step_en <= 1'b0;
        end else begin
            step_en <= 1'b0;
            if (sub_cnt_r >= 16'(STEP_CYC - 1)) begin
                sub_cnt_r <= 16'h0;
                if (tenth_cnt_r >= cfg_r.ramp_time - 16'h1) begin
                    tenth_cnt_r <= 16'h0;
                    step_en <= 1'b1;
                end else begin
                    tenth_cnt_r <= tenth_cnt_r + 16'h1;
                end
            end else begin
                sub_cnt_r <= sub_cnt_r + 16'h1;
            end
        end
    end

    // Output: preset loads at once, else slews toward target
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diam_r <= `WDC_RST_MIN_DIAM;
        end else if (preset) begin
            diam_r <= preset_eff;
        end else if (diam_r < floor_val) begin
            diam_r <= floor_val;
        end else if (step_en) begin
            if (diam_r < target_r) begin
                diam_r <= diam_r + 16'h1;
            end else if (diam_r > target_r) begin
                diam_r <= diam_r - 16'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diameter_o <= `WDC_RST_MIN_DIAM;
            calc_on_o <= 1'b0;
        end else begin
            diameter_o <= diam_r;
            calc_on_o <= calc_on_r;
        end
    end

endmodule

// ### verif/wdc_diameter_chk.sv
// Port checker for the roll diameter calculator
`timescale 1ns/1ps
module wdc_diameter_chk #(
    parameter int STEP_CYC = 400
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Rates and result
    input wire logic signed [15:0] line_speed_i,
    input wire logic signed [15:0] reel_speed_i,
    input wire logic ext_preset_i,
    input wire logic [15:0] diameter_o,
    input wire logic calc_on_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    // Preset loads bypass the slew, so look only where ext_preset_i has been low for three cycles
    sequence quiet_s;
        !ext_preset_i [*3];
    endsequence
    ack_next_a: assert property (req_s |=> ack_o)
        else $error("bus request not answered next cycle");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");
    rd_upper_a: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    rst_val_a: assert property ($fell(rst_i) |->
        diameter_o == 16'h03e8 && !calc_on_o)
        else $error("wrong diameter after reset");
    preset_off_a: assert property (ext_preset_i |-> ##2 !calc_on_o)
        else $error("calculator runs during preset");
    reel_zero_a: assert property (reel_speed_i == 16'sh0000
        |-> ##2 !calc_on_o)
        else $error("calculator runs with zero reel rate");
    line_zero_a: assert property (line_speed_i == 16'sh0000
        |-> ##2 !calc_on_o)
        else $error("calculator runs with zero line rate");
    slew_step_a: assert property (quiet_s |=>
        (diameter_o - $past(diameter_o) + 16'h0001) <= 16'h0002)
        else $error("diameter moved more than one step");
    // Consecutive steps are at least two cycles apart when STEP_CYC is 2 or more
    step_gap_a: assert property (quiet_s ##1 $changed(diameter_o)
        |=> (STEP_CYC < 2) || $stable(diameter_o))
        else $error("diameter stepped on two cycles in a row");
endmodule
bind wdc_diameter_calc wdc_diameter_chk #(.STEP_CYC(STEP_CYC)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .line_speed_i(line_speed_i),
    .reel_speed_i(reel_speed_i), .ext_preset_i(ext_preset_i),
    .diameter_o(diameter_o), .calc_on_o(calc_on_o));

// ### verif/wdc_rate_src.sv
// Line speed source and reel speed feedback model
`timescale 1ns/1ps
module wdc_rate_src (
    // Clock
    input wire logic clk_i,
    // Commanded rates
    input wire logic signed [15:0] line_cmd_i,
    input wire logic signed [15:0] reel_cmd_i,
    // Rates toward the calculator
    output logic signed [15:0] line_speed_o,
    output logic signed [15:0] reel_speed_o
);
    function automatic logic signed [15:0] lim(input logic signed [15:0] v);
        return (v > 16'sh2904) ? 16'sh2904 : (v < -16'sh2904) ? -16'sh2904 : v;
    endfunction
    always_ff @(posedge clk_i) begin
        line_speed_o <= lim(line_cmd_i);
        reel_speed_o <= lim(reel_cmd_i);
    end
endmodule

// ### verif/tb_winder_roll_diameter_calc.sv
// Self-checking bench for the roll diameter calculator
`timescale 1ns/1ps
`include "wdc_defines.svh"
module tb_winder_roll_diameter_calc;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic signed [15:0] line_cmd = 16'sh0000;
    logic signed [15:0] reel_cmd = 16'sh0000;
    logic signed [15:0] line_speed;
    logic signed [15:0] reel_speed;
    logic ext_preset_i = 1'b0;
    logic [15:0] diameter_o;
    logic calc_on_o;
    logic [31:0] rd;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    always #12.5 clk_i = ~clk_i;
    wdc_rate_src src_u (.clk_i(clk_i), .line_cmd_i(line_cmd),
        .reel_cmd_i(reel_cmd), .line_speed_o(line_speed),
        .reel_speed_o(reel_speed));
    wdc_diameter_calc #(.STEP_CYC(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .line_speed_i(line_speed), .reel_speed_i(reel_speed),
        .ext_preset_i(ext_preset_i), .diameter_o(diameter_o),
        .calc_on_o(calc_on_o));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] wd);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        dat_i <= wd;
        sel_i <= 4'h3;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (k >= 50) chk(32'h1, 32'h0);
        @(posedge clk_i);
    endtask
    task automatic wait_diam(input logic [15:0] exp, input int lim);
        n = 0;
        while (diameter_o !== exp && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk(diameter_o, exp);
    endtask
    // Rates settle well past the divider latency
    task automatic rates(input logic signed [15:0] l,
                         input logic signed [15:0] r);
        line_cmd <= l;
        reel_cmd <= r;
        repeat (40) @(posedge clk_i);
    endtask
    task automatic t_reset;
        logic [7:0] a [8];
        logic [15:0] e [8];
        a = '{`WDC_OFF_CTRL, `WDC_OFF_MIN_DIAM, `WDC_OFF_MIN_SPEED,
              `WDC_OFF_PRESET, `WDC_OFF_RAMP, `WDC_OFF_DIAM,
              `WDC_OFF_STATUS, 8'h1c};
        e = '{16'h0000, 16'h03e8, 16'h01f4, 16'h03e8, 16'h0032, 16'h03e8,
              16'h0004, 16'h0000};
        chk(diameter_o, 32'h03e8);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, a[i], 32'h0);
            chk(rd, {16'h0000, e[i]});
        end
        $display("test reset done");
    endtask
    task automatic t_calc;
        rates(16'sh1388, 16'sh2710);
        chk(calc_on_o, 1'b0);
        chk(diameter_o, 32'h03e8);
        bus(1'b1, `WDC_OFF_MIN_DIAM, 32'h03e8);
        bus(1'b1, `WDC_OFF_RAMP, 32'h1);
        bus(1'b1, `WDC_OFF_CTRL, 32'h1);
        // 4000 counts at one step per two cycles
        wait_diam(16'h1388, 9000);
        chk(calc_on_o, 1'b1);
        chk(n >= 7995 && n <= 8050, 1'b1);
        $display("test calc done");
    endtask
    task automatic t_hold;
        rates(16'sh01f4, 16'sh2710);
        chk(calc_on_o, 1'b0);
        rates(-16'sh1388, 16'sh2710);
        chk(calc_on_o, 1'b1);
        rates(16'sh0fa0, 16'sh0000);
        chk(calc_on_o, 1'b0);
        chk(diameter_o, 32'h1388);
        rates(16'sh0032, 16'sh2710);
        repeat (200) @(posedge clk_i);
        chk(diameter_o, 32'h1388);
        $display("test hold done");
    endtask
    task automatic t_floor_preset;
        rates(16'sh0258, 16'sh2710);
        wait_diam(16'h03e8, 8200);
        bus(1'b1, `WDC_OFF_PRESET, 32'h4e20);
        bus(1'b0, `WDC_OFF_PRESET, 32'h0);
        chk(rd, 32'h2710);
        bus(1'b1, `WDC_OFF_PRESET, 32'h0bb8);
        ext_preset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(diameter_o, 32'h0bb8);
        chk(calc_on_o, 1'b0);
        bus(1'b0, `WDC_OFF_STATUS, 32'h0);
        chk(rd, 32'h6);
        bus(1'b1, `WDC_OFF_CTRL, 32'h3);
        ext_preset_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(diameter_o, 32'h0bb8);
        chk(calc_on_o, 1'b0);
        bus(1'b1, `WDC_OFF_RAMP, 32'h0);
        bus(1'b0, `WDC_OFF_RAMP, 32'h0);
        chk(rd, 32'h1);
        bus(1'b1, `WDC_OFF_RAMP, 32'h1b58);
        bus(1'b0, `WDC_OFF_RAMP, 32'h0);
        chk(rd, 32'h1770);
        $display("test floor preset done");
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Whole run needs about 17000 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            complete_run;
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_calc;
        t_hold;
        t_floor_preset;
        complete_run;
    end
endmodule
